// >>> verilog/output_channel_config_decoder.sv
// output channel configuration decoder with apb register access
`timescale 1ns/10ps
`default_nettype none
module output_channel_config_decoder
    import chan_cfg_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host control pins
    input wire logic [num_channels-1:0] channel_on_n,
    input wire logic channel_six_driver_enable,
    input wire logic external_off_high,
    input wire logic external_off_low,
    // per-channel gate drive
    output logic [num_channels-1:0] gate_drive,
    output logic [num_channels-1:0] channel_side,
    output logic [num_channels-1:0] channel_fet_type
);
    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [num_channels-1:0] channel_side_select;
    logic [num_channels-1:0] channel_fet_type_select;
    logic [grp_width-1:0] group_select;
    logic [num_channels-1:0] next_side_select;
    logic [num_channels-1:0] next_fet_select;
    logic [grp_width-1:0] next_group_select;
    logic [31:0] next_prdata;
    logic [31:0] read_word;
    logic [31:0] status_word;
    logic [31:0] drive_word;
    logic fet_fault;
    logic off_active;
    logic setup_phase;
    logic access;
    logic write_hit;
    logic read_setup;
    logic hit_side;
    logic hit_fet;
    logic hit_group;
    logic hit_status;
    logic hit_drive;
    logic hit_ident;
    logic hit_none;

    // bus phases
    assign setup_phase = psel && !penable;
    assign access = psel && penable;
    assign write_hit = access && pwrite;
    assign read_setup = setup_phase && !pwrite;
    // zero wait states: read data is fetched in the setup cycle so it stands at the access edge
    assign pready = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    assign hit_side = (paddr == addr_side);
    assign hit_fet = (paddr == addr_fet);
    assign hit_group = (paddr == addr_group);
    assign hit_status = (paddr == addr_status);
    assign hit_drive = (paddr == addr_drive);
    assign hit_ident = (paddr == addr_ident);
    assign hit_none = !(hit_side || hit_fet || hit_group || hit_status || hit_drive || hit_ident);
    // unmapped offsets are flagged in the access phase only
    assign pslverr = access && hit_none;

    // status pins are read live, not latched
    always_comb
    begin
        status_word = 32'h00000000;
        status_word[st_fet_fault] = fet_fault;
        status_word[st_ch6_en] = channel_six_driver_enable;
        status_word[st_off_active] = off_active;
    end
    assign drive_word = {8'h00, channel_fet_type, channel_side, gate_drive};

    // read mux; unmapped offsets read as zero
    always_comb
    begin
        read_word = 32'h00000000;
        if (hit_side)
            read_word = {24'h000000, channel_side_select};
        if (hit_fet)
            read_word = {24'h000000, channel_fet_type_select};
        if (hit_group)
            read_word = {28'h0000000, group_select};
        if (hit_status)
            read_word = status_word;
        if (hit_drive)
            read_word = drive_word;
        if (hit_ident)
            read_word = ident_value;
    end

    // writes land only at the access edge; read-only offsets ignore them
    always_comb
    begin
        next_side_select = channel_side_select;
        next_fet_select = channel_fet_type_select;
        next_group_select = group_select;
        next_prdata = prdata;
        if (write_hit && hit_side)
            next_side_select = pwdata[num_channels-1:0];
        if (write_hit && hit_fet)
            next_fet_select = pwdata[num_channels-1:0];
        if (write_hit && hit_group)
            next_group_select = pwdata[grp_width-1:0];
        if (read_setup)
            next_prdata = read_word;
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            channel_side_select <= side_reset;
            channel_fet_type_select <= fet_reset;
            group_select <= group_reset;
            prdata <= 32'h00000000;
        end
        else
        begin
            channel_side_select <= next_side_select;
            channel_fet_type_select <= next_fet_select;
            group_select <= next_group_select;
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // side and fet decoding
    logic peak_hold_pair_a_select;
    logic peak_hold_pair_b_select;
    logic bridge_a_select;
    logic bridge_b_select;
    logic [num_channels-1:0] next_side;
    logic [num_channels-1:0] next_fet;
    logic [num_channels-1:0] next_fault;
    logic next_fet_fault;

    assign peak_hold_pair_a_select = group_select[grp_ph_a];
    assign peak_hold_pair_b_select = group_select[grp_ph_b];
    assign bridge_a_select = group_select[grp_br_a];
    assign bridge_b_select = group_select[grp_br_b];

    always_comb
    begin
        next_side = channel_side_select;
        // peak-hold first, bridge after so the bridge overrides
        if (peak_hold_pair_a_select)
        begin
            next_side[ch1] = side_high;
            next_side[ch4] = side_low;
        end
        if (peak_hold_pair_b_select)
        begin
            next_side[ch2] = side_high;
            next_side[ch3] = side_low;
        end
        if (bridge_a_select)
        begin
            next_side[ch1] = side_high;
            next_side[ch2] = side_high;
            next_side[ch3] = side_low;
            next_side[ch4] = side_low;
        end
        if (bridge_b_select)
        begin
            next_side[ch5] = side_high;
            next_side[ch6] = side_high;
            next_side[ch7] = side_low;
            next_side[ch8] = side_low;
        end
    end

    // a p-type request on a low-side channel is refused: drive as n-type, flag it
    genvar g;
    generate
        for (g = 0; g < num_channels; g++)
        begin : g_fet
            // high-side channels keep their own type inside a group as well
            assign next_fet[g] = (next_side[g] == side_high)
                ? channel_fet_type_select[g]
                : fet_n;
            assign next_fault[g] = (next_side[g] == side_low)
                && (channel_fet_type_select[g] == fet_p);
        end
    endgenerate
    assign next_fet_fault = |next_fault;

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            channel_side <= side_reset;
            channel_fet_type <= fet_reset;
            fet_fault <= 1'b0;
        end
        else
        begin
            channel_side <= next_side;
            channel_fet_type <= next_fet;
            fet_fault <= next_fet_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bridges
    logic [bridge_channels-1:0] bridge_gate [num_bridges];
    logic [num_bridges-1:0] bridge_sel;

    // the bridge state runs whether or not its group is selected
    assign bridge_sel = {bridge_b_select, bridge_a_select};

    generate
        for (g = 0; g < num_bridges; g++)
        begin : g_bridge
            logic pwm_n;
            logic reverse;
            logic float_req;
            // the fourth pin of a group has no job in bridge mode
            assign pwm_n = channel_on_n[g*bridge_channels];
            assign reverse = !channel_on_n[g*bridge_channels+1];
            assign float_req = !channel_on_n[g*bridge_channels+2];
            bridge_ctrl u_bridge (
                .mclk(mclk),
                .nrst(nrst),
                .bridge_modulation_n(pwm_n),
                .bridge_direction(reverse),
                .bridge_float_control(float_req),
                .gate_on(bridge_gate[g]),
                .state()
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // gate drive with disable and channel six enable
    logic [num_channels-1:0] demand;
    logic [num_channels-1:0] next_drive;
    logic [num_channels-1:0] off_exempt;
    logic [num_channels-1:0] off_allow;
    logic [num_channels-1:0] enable_allow;
    logic off_by_high;
    logic off_by_low;

    // either pin alone is enough; the pair is redundant on purpose
    assign off_by_high = external_off_high;
    assign off_by_low = !external_off_low;
    assign off_active = off_by_high || off_by_low;
    // channels 7 and 8 stay usable for limp-home loads while the others are off
    assign off_exempt = {1'b1, 1'b1, 6'h00};

    generate
        for (g = 0; g < num_channels; g++)
        begin : g_drive
            localparam int b = g / bridge_channels;
            localparam int k = g % bridge_channels;
            // plain channels take one flop; bridge channels take two, the bridge state and then gate_drive
            assign demand[g] = bridge_sel[b]
                ? bridge_gate[b][k]
                : !channel_on_n[g];
            assign off_allow[g] = off_exempt[g] || !off_active;
            assign enable_allow[g] = (g != ch6) || channel_six_driver_enable;
            assign next_drive[g] = demand[g] && off_allow[g] && enable_allow[g];
        end
    endgenerate

    // reset keeps every gate dark; once nrst is high the gates follow demand from the next edge
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            gate_drive <= 8'h00;
        else
            gate_drive <= next_drive;
    end
endmodule
`default_nettype wire

// >>> verilog/chan_cfg_pkg.sv
// constants and types for the output channel configuration decoder
package chan_cfg_pkg;
    localparam int num_channels = 8;
    localparam int bridge_channels = 4;
    localparam int num_bridges = 2;

    // channel indices, zero based (channel 1 is index 0)
    localparam int ch1 = 0;
    localparam int ch2 = 1;
    localparam int ch3 = 2;
    localparam int ch4 = 3;
    localparam int ch5 = 4;
    localparam int ch6 = 5;
    localparam int ch7 = 6;
    localparam int ch8 = 7;

    // side encoding
    localparam logic side_low = 1'b0;
    localparam logic side_high = 1'b1;
    // fet type encoding
    localparam logic fet_n = 1'b0;
    localparam logic fet_p = 1'b1;

    // register map, byte addresses
    localparam logic [11:0] addr_side = 12'h000;
    localparam logic [11:0] addr_fet = 12'h004;
    localparam logic [11:0] addr_group = 12'h008;
    localparam logic [11:0] addr_status = 12'h00C;
    localparam logic [11:0] addr_drive = 12'h010;
    localparam logic [11:0] addr_ident = 12'h014;

    // group register fields
    localparam int grp_ph_a = 0;
    localparam int grp_ph_b = 1;
    localparam int grp_br_a = 2;
    localparam int grp_br_b = 3;
    localparam int grp_width = 4;

    // status register fields
    localparam int st_fet_fault = 0;
    localparam int st_ch6_en = 1;
    localparam int st_off_active = 2;

    localparam logic [7:0] side_reset = 8'h00;
    localparam logic [7:0] fet_reset = 8'h00;
    localparam logic [3:0] group_reset = 4'h0;

    // arbitrary value, identifies this block's register layout only
    localparam logic [31:0] ident_value = 32'h0000_C0DE;

    typedef enum logic [1:0] {
        br_off = 2'b00,
        br_fwd = 2'b01,
        br_rev = 2'b11,
        br_float = 2'b10
    } bridge_state_e;
endpackage

// >>> verilog/bridge_ctrl.sv
// one h-bridge: turns pwm, direction and float controls into four gate commands
`timescale 1ns/10ps
`default_nettype none
module bridge_ctrl
    import chan_cfg_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // controls, active low pwm
    input wire logic bridge_modulation_n,
    input wire logic bridge_direction,
    input wire logic bridge_float_control,
    // gate commands: hs1, hs2, ls1, ls2
    output logic [bridge_channels-1:0] gate_on,
    output bridge_state_e state
);
    bridge_state_e next_state;

    always_comb
    begin
        if (bridge_float_control)
            next_state = br_float;
        else if (bridge_modulation_n)
            next_state = br_off;
        else if (bridge_direction)
            next_state = br_rev;
        else
            next_state = br_fwd;
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            state <= br_off;
        else
            state <= next_state;
    end

    // diagonal pairs; float drops all four gates, off keeps the bridge dark too
    always_comb
    begin
        unique case (state)
            br_fwd: gate_on = 4'b1001;   // hs1 + ls2
            br_rev: gate_on = 4'b0110;   // hs2 + ls1
            br_off: gate_on = 4'b0000;
            br_float: gate_on = 4'b0000;
        endcase
    end
endmodule
`default_nettype wire

// >>> testbench/occd_asserts.sv
// pin-level checks for the output channel configuration decoder
`timescale 1ns/10ps
`default_nettype none
module occd_asserts (
    // clock, reset and bus
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    // host pins
    input wire logic [7:0] channel_on_n,
    input wire logic channel_six_driver_enable,
    input wire logic external_off_high,
    input wire logic external_off_low,
    // decoded outputs
    input wire logic [7:0] gate_drive,
    input wire logic [7:0] channel_side,
    input wire logic [7:0] channel_fet_type
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // two samples cover both the plain and the bridge path latency
    sequence en6_low; !channel_six_driver_enable [*2]; endsequence
    sequence off_hi; external_off_high [*2]; endsequence
    sequence off_lo; !external_off_low [*2]; endsequence
    AST_READY: assert property (psel |-> pready)
        else $error("pready low in a transfer");
    AST_ERR: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside an access");
    AST_P_HIGH: assert property ((channel_fet_type & ~channel_side) == 8'h00)
        else $error("p-type on a low-side channel");
    AST_SIDE_WR: assert property ($changed(channel_side) && $past(nrst) |-> $past(psel && penable && pwrite, 2))
        else $error("side moved without a write");
    AST_FET_WR: assert property ($changed(channel_fet_type) && $past(nrst) |-> $past(psel && penable && pwrite, 2))
        else $error("fet type moved without a write");
    AST_CH6: assert property (en6_low |=> !gate_drive[5])
        else $error("channel 6 on while not enabled");
    AST_OFF_HI: assert property (off_hi |=> gate_drive[5:0] == 6'h00)
        else $error("output on under high disable");
    AST_OFF_LO: assert property (off_lo |=> gate_drive[5:0] == 6'h00)
        else $error("output on under low disable");
    AST_CH8: assert property (channel_side[7] && $past(channel_side[7]) |-> gate_drive[7] == !$past(channel_on_n[7]))
        else $error("channel 8 not following its input");
endmodule
////////////////////
bind output_channel_config_decoder occd_asserts chk (.mclk(mclk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .channel_on_n(channel_on_n),
    .channel_six_driver_enable(channel_six_driver_enable), .external_off_high(external_off_high),
    .external_off_low(external_off_low), .gate_drive(gate_drive), .channel_side(channel_side),
    .channel_fet_type(channel_fet_type));
`default_nettype wire

// >>> testbench/host_model.sv
// host side: drives on/off, enable and disable pins
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // commands from the bench
    input wire logic mclk,
    input wire logic [7:0] on_cmd,
    input wire logic en_cmd,
    input wire logic [1:0] off_cmd,
    // pins to the device
    output logic [7:0] channel_on_n,
    output logic channel_six_driver_enable,
    output logic external_off_high,
    output logic external_off_low
);
    // pins idle high, except external_off_high which idles low
    initial
    begin
        channel_on_n = 8'hFF;
        channel_six_driver_enable = 1'b1;
        external_off_high = 1'b0;
        external_off_low = 1'b1;
        // one process owns the pins, so each has a single driver
        forever
        begin
            @(posedge mclk);
            channel_on_n <= ~on_cmd;
            channel_six_driver_enable <= en_cmd;
            external_off_high <= off_cmd[0];
            external_off_low <= ~off_cmd[1];
        end
    end
endmodule
`default_nettype wire

// >>> testbench/output_channel_config_decoder_bench.sv
// self-checking bench for the output channel configuration decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("Error %s expected %h seen %h", n, e, g); end end
module output_channel_config_decoder_bench import chan_cfg_pkg::*;;
    logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, en6 = 1, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, seed = 32'h5F85, prdata;
    logic pready, pslverr, channel_six_driver_enable, external_off_high, external_off_low;
    logic [7:0] on_cmd = 8'h00, channel_on_n, gate_drive, channel_side, channel_fet_type;
    logic [1:0] off = 2'b00;
    logic [23:0] exp;
    int fail_count = 0, checks = 0, cyc = 0;
    output_channel_config_decoder dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .channel_on_n(channel_on_n), .channel_six_driver_enable(channel_six_driver_enable),
        .external_off_high(external_off_high), .external_off_low(external_off_low), .gate_drive(gate_drive),
        .channel_side(channel_side), .channel_fet_type(channel_fet_type));
    host_model host (.mclk(mclk), .on_cmd(on_cmd), .en_cmd(en6), .off_cmd(off), .channel_on_n(channel_on_n),
        .channel_six_driver_enable(channel_six_driver_enable), .external_off_high(external_off_high),
        .external_off_low(external_off_low));
    initial
    begin
        forever #50 mclk = ~mclk;
    end
    ////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            tally_and_finish;
        end
    end
    function automatic logic [31:0] xs;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // response and read data are taken at the edge where pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    // bridge claims are applied last so they win over peak-hold
    function automatic logic [23:0] model(int s, int f, int g, int o);
        int gt;
        gt = o;
        if (g[0]) s = (s | 1) & ~8;
        if (g[1]) s = (s | 2) & ~4;
        if (g[2]) s = (s | 3) & ~12;
        if (g[3]) s = (s | 48) & ~192;
        for (int b = 0; b < 8; b += 4)
            if (g[2 + b / 4])
            begin
                gt &= ~(15 << b);
                if (o[b] && !o[b + 2]) gt |= (o[b + 1] ? 6 : 9) << b;
            end
        if (off != 2'b00) gt &= ~63;
        if (!en6) gt &= ~32;
        return {8'(f & s), 8'(s), 8'(gt)};
    endfunction
    task automatic run(int s, int f, int g, int o);
        f &= int'(model(s, 0, g, 0) >> 8);
        apb(1'b1, addr_side, s);
        apb(1'b1, addr_fet, f);
        apb(1'b1, addr_group, g);
        on_cmd <= o[7:0];
        repeat (4) @(posedge mclk);
        exp = model(s, f, g, o[7:0]);
        `CHK("side", exp[15:8], channel_side)
        `CHK("fet", exp[23:16], channel_fet_type)
        `CHK("gate", exp[7:0], gate_drive)
        apb(1'b0, addr_drive, 0);
        `CHK("drive read", {8'h00, exp}, rd)
        apb(1'b0, addr_status, 0);
        `CHK("status", {29'h00000000, off != 2'b00, en6, 1'b0}, rd)
    endtask
    ////////////////////
    initial
    begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        `CHK("gate at reset", 8'h00, gate_drive)
        apb(1'b0, addr_group, 0);
        `CHK("group reset", 32'h0, rd)
        apb(1'b1, addr_ident, 32'h1234);
        apb(1'b0, addr_ident, 0);
        `CHK("ident", ident_value, rd)
        apb(1'b1, 12'h018, 32'hFF);
        `CHK("unmapped err", 1'b1, err)
        apb(1'b0, addr_side, 0);
        `CHK("side after bad write", 32'h0, rd)
        $display("test registers done");
        for (int g = 0; g < 16; g++) run(8'h96, 8'hFF, g, xs());
        $display("test groups done");
        for (int i = 0; i < 8; i++)
        begin
            en6 <= i[0];
            off <= i[2:1];
            run(8'h0F, 8'hFF, i > 5 ? 12 : 0, 8'hFB);
        end
        $display("test disables done");
        repeat (60)
        begin
            en6 <= xs() % 4 != 0;
            off <= xs() % 3 == 0 ? 2'(xs()) : 2'b00;
            run(xs(), xs(), xs() & 15, xs());
        end
        $display("test random done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
